// ===== rtl/prot_event_defines.svh
// constants of the protection event reporting block
// assumes a 10 MHz module clock; included by the package user modules
`ifndef PROT_EVENT_DEFINES_SVH
`define PROT_EVENT_DEFINES_SVH

`define CLK_KHZ            10000
`define HS_EF_SHORT_MS     100
`define HS_EF_LONG_MS      750
`define HS_EF_EXT_MS       1000
`define HS_EF_RST_MS       100
`define HS_EF_INT_RST_MS   500
`define HS_EF_EXT_CAP_MS   500

`define OC_MASK_RST        8'h55
`define EF_MASK_RST        8'h55
`define OUT_MASK_RST       10'h300
`define BYTE_MAX           10'h0ff
`define OUT_MASK_MAX       10'h3ff
`define ANGLE_MAX          10'h003
`define OPSEL_MAX          10'h002
`define BIT_MAX            10'h001

`define SEL_OC_MASK        3'h0
`define SEL_EF_MASK        3'h1
`define SEL_OUT_MASK       3'h2
`define SEL_ANGLE          3'h3
`define SEL_OP_TIME        3'h4
`define SEL_INTERMIT       3'h5
`define SEL_ROUTE          3'h6
`define SEL_TEXT           3'h7

`define ANG_0              8'h00
`define ANG_M30            8'he2
`define ANG_M60            8'hc4
`define ANG_M90            8'ha6

`define STAMP_W            16
`define TEXT_W             8
`define CODE_W             6
`define EV_N               26
`define RESTART_BIT        26
`define OVF_BIT            27
`define CODE_RESTART       6'h32
`define CODE_OVERFLOW      6'h33

`endif

// ===== rtl/prot_event_pkg.sv
// types shared by the protection event reporting block
// assumes the constants header is included by each user
package prot_event_pkg;
  typedef enum logic [3:0] {
    EF_IDLE = 4'h1,
    EF_RUN  = 4'h2,
    EF_GAP  = 4'h4,
    EF_TRIP = 4'h8
  } ef_state_e;

  typedef enum logic [1:0] {
    OPT_SHORT = 2'h0,
    OPT_LONG  = 2'h1,
    OPT_EXT   = 2'h2
  } op_time_e;

  typedef logic [5:0] ev_code_t;
endpackage

// ===== rtl/event_queue.sv
// shift queue for event records; head always sits in entry 0
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ns
module event_queue #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_push_valid,
  output logic                  o_push_ready,
  input  wire logic [WIDTH-1:0] i_push_data,
  output logic                  o_pop_valid,
  input  wire logic             i_pop_ready,
  output logic [WIDTH-1:0]      o_pop_data
);
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("event_queue: depth below two or empty width");
  end

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic             pop;
  logic             push;

  // no pass-through when full: simpler, costs one cycle of stall
  assign o_push_ready = ~vld_r[DEPTH-1];
  assign o_pop_valid  = vld_r[0];
  assign o_pop_data   = mem_r[0];
  assign pop          = vld_r[0] & i_pop_ready;
  assign push         = i_push_valid & ~vld_r[DEPTH-1];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
      vld_nxt[i] = vld_r[i];
      if (pop) begin
        mem_nxt[i] = (i < DEPTH - 1) ? mem_r[i+1] : mem_r[i];
        vld_nxt[i] = (i < DEPTH - 1) ? vld_r[i+1] : 1'b0;
      end
    end
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (push && !vld_nxt[i] && (i == 0 || vld_nxt[(i > 0) ? i-1 : 0])) begin
        mem_nxt[i] = i_push_data;
        vld_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    mem_r <= mem_nxt;
    if (!i_rstn) begin
      vld_r <= '0;
    end else begin
      vld_r <= vld_nxt;
    end
  end
endmodule

// ===== rtl/protection_event_reporting.sv
// stage gating, high-set earth-fault timing, settings and event reporting
// assumes setting writes and event ready come from same-clock bus logic;
// stage inputs are asynchronous and are synchronised here
`timescale 1ns/1ns
`include "prot_event_defines.svh"
module protection_event_reporting #(
  parameter int unsigned CYC_PER_MS   = `CLK_KHZ,
  parameter int unsigned OP_SHORT_CYC = `HS_EF_SHORT_MS * `CLK_KHZ,
  parameter int unsigned OP_LONG_CYC  = `HS_EF_LONG_MS * `CLK_KHZ,
  parameter int unsigned OP_EXT_CYC   = `HS_EF_EXT_MS * `CLK_KHZ,
  parameter int unsigned RST_CYC      = `HS_EF_RST_MS * `CLK_KHZ,
  parameter int unsigned INT_RST_CYC  = `HS_EF_INT_RST_MS * `CLK_KHZ,
  parameter int unsigned EXT_CAP_CYC  = `HS_EF_EXT_CAP_MS * `CLK_KHZ,
  parameter int          QDEPTH       = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_ls_oc_start,
  input  wire logic         i_ls_oc_operate,
  input  wire logic         i_hs_oc_start,
  input  wire logic         i_hs_oc_operate,
  input  wire logic         i_ef_ls_start,
  input  wire logic         i_ef_ls_operate,
  input  wire logic         i_residual_voltage_start,
  input  wire logic         i_ef_hs_pickup,
  input  wire logic         i_signal_one,
  input  wire logic         i_signal_two,
  input  wire logic         i_signal_three,
  input  wire logic         i_set_wr,
  input  wire logic [2:0]   i_set_sel,
  input  wire logic [9:0]   i_set_data,
  input  wire logic         i_ev_ready,
  output logic              o_ls_oc_operate,
  output logic              o_hs_oc_trip,
  output logic              o_ef_hs_start,
  output logic              o_ef_hs_trip,
  output logic              o_trip_signal_one,
  output logic              o_trip_signal_two,
  output logic [7:0]        o_basic_angle,
  output logic [7:0]        o_overcurrent_event_mask,
  output logic [7:0]        o_earth_fault_event_mask,
  output logic [9:0]        o_output_signal_event_mask,
  output logic              o_set_ack,
  output logic              o_set_rej,
  output logic              o_ev_valid,
  output logic [15:0]       o_ev_stamp,
  output logic [7:0]        o_ev_text,
  output logic [5:0]        o_ev_code
);
  localparam int RECW = `STAMP_W + `TEXT_W + `CODE_W;

  if (OP_LONG_CYC >= 2**24 || OP_EXT_CYC >= 2**24 || INT_RST_CYC >= 2**24 ||
      OP_SHORT_CYC < 1 || RST_CYC < 1 || EXT_CAP_CYC >= 2**24 ||
      CYC_PER_MS < 1 || CYC_PER_MS >= 2**14) begin : g_bad
    $error("protection_event_reporting: timing count out of range");
  end

  // two-flop synchronisers for the asynchronous stage inputs
  logic [10:0] raw;
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  assign raw = {i_signal_three, i_signal_two, i_signal_one, i_ef_hs_pickup,
                i_residual_voltage_start, i_ef_ls_operate, i_ef_ls_start,
                i_hs_oc_operate, i_hs_oc_start, i_ls_oc_operate, i_ls_oc_start};
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end
  logic ls_start_s, ls_op_s, hs_s, hs_op_s, efl_start_s, efl_op_s;
  logic u0_s, pick_s, ss1_s, ss2_s, ss3_s;
  assign {ss3_s, ss2_s, ss1_s, pick_s, u0_s, efl_op_s, efl_start_s,
          hs_op_s, hs_s, ls_op_s, ls_start_s} = sync2_r;

  // ---------------- settings ----------------
  logic [7:0] oc_mask_r, oc_mask_nxt, ef_mask_r, ef_mask_nxt, text_r, text_nxt;
  logic [9:0] out_mask_r, out_mask_nxt, set_max;
  logic [1:0] angle_r, angle_nxt;
  prot_event_pkg::op_time_e opsel_r, opsel_nxt;
  logic       intermit_r, intermit_nxt, route_r, route_nxt;
  logic       ack_nxt, rej_nxt;

  always_comb begin
    oc_mask_nxt  = oc_mask_r;
    ef_mask_nxt  = ef_mask_r;
    out_mask_nxt = out_mask_r;
    angle_nxt    = angle_r;
    opsel_nxt    = opsel_r;
    intermit_nxt = intermit_r;
    route_nxt    = route_r;
    text_nxt     = text_r;
    ack_nxt      = 1'b0;
    rej_nxt      = 1'b0;
    unique case (i_set_sel)
      `SEL_OC_MASK, `SEL_EF_MASK, `SEL_TEXT: set_max = `BYTE_MAX;
      `SEL_OUT_MASK: set_max = `OUT_MASK_MAX;
      `SEL_ANGLE:    set_max = `ANGLE_MAX;
      `SEL_OP_TIME:  set_max = `OPSEL_MAX;
      `SEL_INTERMIT, `SEL_ROUTE: set_max = `BIT_MAX;
    endcase
    if (i_set_wr) begin
      if (i_set_data > set_max) begin
        rej_nxt = 1'b1;
      end else begin
        ack_nxt = 1'b1;
        unique case (i_set_sel)
          `SEL_OC_MASK:  oc_mask_nxt  = i_set_data[7:0];
          `SEL_EF_MASK:  ef_mask_nxt  = i_set_data[7:0];
          `SEL_OUT_MASK: out_mask_nxt = i_set_data;
          `SEL_ANGLE:    angle_nxt    = i_set_data[1:0];
          `SEL_OP_TIME:  opsel_nxt    = prot_event_pkg::op_time_e'(i_set_data[1:0]);
          `SEL_INTERMIT: intermit_nxt = i_set_data[0];
          `SEL_ROUTE:    route_nxt    = i_set_data[0];
          `SEL_TEXT:     text_nxt     = i_set_data[7:0];
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      oc_mask_r  <= `OC_MASK_RST;
      ef_mask_r  <= `EF_MASK_RST;
      out_mask_r <= `OUT_MASK_RST;
      angle_r    <= 2'h0;
      opsel_r    <= prot_event_pkg::OPT_SHORT;
      intermit_r <= 1'b0;
      route_r    <= 1'b0;
      text_r     <= 8'h00;
      o_set_ack  <= 1'b0;
      o_set_rej  <= 1'b0;
    end else begin
      oc_mask_r  <= oc_mask_nxt;
      ef_mask_r  <= ef_mask_nxt;
      out_mask_r <= out_mask_nxt;
      angle_r    <= angle_nxt;
      opsel_r    <= opsel_nxt;
      intermit_r <= intermit_nxt;
      route_r    <= route_nxt;
      text_r     <= text_nxt;
      o_set_ack  <= ack_nxt;
      o_set_rej  <= rej_nxt;
    end
  end
  assign o_overcurrent_event_mask   = oc_mask_r;
  assign o_earth_fault_event_mask   = ef_mask_r;
  assign o_output_signal_event_mask = out_mask_r;

  // ---------------- high-set earth-fault timing ----------------
  prot_event_pkg::ef_state_e st_r, st_nxt;
  logic [23:0] op_r, op_nxt, rc_r, rc_nxt, gap_r, gap_nxt;
  logic [23:0] op_lim, gap_lim;
  localparam logic [23:0] TRIP_RST_LIM = 24'(RST_CYC - 1);
  localparam logic [23:0] EXT_CAP      = 24'(EXT_CAP_CYC);

  always_comb begin
    unique case (opsel_r)
      prot_event_pkg::OPT_LONG: op_lim = 24'(OP_LONG_CYC - 1);
      prot_event_pkg::OPT_EXT:  op_lim = 24'(OP_EXT_CYC - 1);
      default:                  op_lim = 24'(OP_SHORT_CYC - 1);
    endcase
    gap_lim = intermit_r ? 24'(INT_RST_CYC - 1) : 24'(RST_CYC - 1);
    st_nxt  = st_r;
    op_nxt  = op_r;
    rc_nxt  = rc_r;
    gap_nxt = gap_r;
    unique case (st_r)
      prot_event_pkg::EF_IDLE: begin
        if (pick_s) begin
          st_nxt  = prot_event_pkg::EF_RUN;
          op_nxt  = 24'h00_0000;
          gap_nxt = 24'h00_0000;
        end
      end
      prot_event_pkg::EF_RUN: begin
        if (!pick_s) begin
          st_nxt = prot_event_pkg::EF_GAP;
          rc_nxt = 24'h00_0000;
        end else if (op_r >= op_lim) begin
          st_nxt = prot_event_pkg::EF_TRIP;
        end else begin
          op_nxt = op_r + 24'h00_0001;
        end
      end
      prot_event_pkg::EF_GAP: begin
        if (pick_s) begin
          st_nxt = prot_event_pkg::EF_RUN;
        end else if (rc_r >= gap_lim) begin
          st_nxt = prot_event_pkg::EF_IDLE;
        end else begin
          rc_nxt = rc_r + 24'h00_0001;
          // gap time delays the trip only while the extension budget lasts
          if (intermit_r && gap_r < EXT_CAP) begin
            gap_nxt = gap_r + 24'h00_0001;
          end else if (op_r < op_lim) begin
            op_nxt = op_r + 24'h00_0001;
          end
        end
      end
      prot_event_pkg::EF_TRIP: begin
        if (pick_s) begin
          rc_nxt = 24'h00_0000;
        end else if (rc_r >= TRIP_RST_LIM) begin
          st_nxt = prot_event_pkg::EF_IDLE;
        end else begin
          rc_nxt = rc_r + 24'h00_0001;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_r  <= prot_event_pkg::EF_IDLE;
      op_r  <= 24'h00_0000;
      rc_r  <= 24'h00_0000;
      gap_r <= 24'h00_0000;
    end else begin
      st_r  <= st_nxt;
      op_r  <= op_nxt;
      rc_r  <= rc_nxt;
      gap_r <= gap_nxt;
    end
  end

  // ---------------- stage outputs ----------------
  logic ls_nxt, hs_trip_nxt, ef_trip_nxt;
  logic [7:0] ang_nxt;
  always_comb begin
    ls_nxt      = ls_op_s & ~hs_s;
    hs_trip_nxt = hs_op_s & route_r;
    ef_trip_nxt = (st_nxt == prot_event_pkg::EF_TRIP);
    unique case (angle_r)
      2'h0: ang_nxt = `ANG_0;
      2'h1: ang_nxt = `ANG_M30;
      2'h2: ang_nxt = `ANG_M60;
      2'h3: ang_nxt = `ANG_M90;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_ls_oc_operate   <= 1'b0;
      o_hs_oc_trip      <= 1'b0;
      o_ef_hs_start     <= 1'b0;
      o_ef_hs_trip      <= 1'b0;
      o_trip_signal_one <= 1'b0;
      o_trip_signal_two <= 1'b0;
      o_basic_angle     <= `ANG_0;
    end else begin
      o_ls_oc_operate   <= ls_nxt;
      o_hs_oc_trip      <= hs_trip_nxt;
      o_ef_hs_start     <= (st_nxt != prot_event_pkg::EF_IDLE);
      o_ef_hs_trip      <= ef_trip_nxt;
      o_trip_signal_one <= ls_nxt | hs_trip_nxt;
      o_trip_signal_two <= ef_trip_nxt;
      o_basic_angle     <= ang_nxt;
    end
  end

  // ---------------- events ----------------
  logic [12:0] mon, mon_prev_r;
  logic [25:0] ev_raw, ev_new, mask_all;
  logic [27:0] pend_r, pend_nxt;
  logic [4:0]  sel_idx;
  logic [5:0]  push_code;
  logic [15:0] stamp_r, stamp_nxt;
  logic [13:0] pre_r, pre_nxt;
  logic        q_ready, q_push;

  assign mon = {o_trip_signal_two, ss3_s, ss2_s, ss1_s, o_trip_signal_one,
                o_ef_hs_trip, u0_s, efl_op_s, efl_start_s,
                o_hs_oc_trip, hs_s, o_ls_oc_operate, ls_start_s};
  for (genvar g = 0; g < 13; g++) begin : g_edge
    assign ev_raw[2*g]   = mon[g] & ~mon_prev_r[g];
    assign ev_raw[2*g+1] = ~mon[g] & mon_prev_r[g];
  end
  assign mask_all = {out_mask_r, ef_mask_r, oc_mask_r};
  assign ev_new   = ev_raw & mask_all;

  always_comb begin
    sel_idx = 5'h00;
    for (int k = 27; k >= 0; k--) begin
      if (pend_r[k]) begin
        sel_idx = 5'(k);
      end
    end
    if (sel_idx == 5'(`RESTART_BIT)) begin
      push_code = `CODE_RESTART;
    end else if (sel_idx == 5'(`OVF_BIT)) begin
      push_code = `CODE_OVERFLOW;
    end else begin
      push_code = {1'b0, sel_idx} + 6'h01;
    end
    q_push   = (|pend_r) & q_ready;
    pend_nxt = pend_r;
    if (q_push) begin
      pend_nxt[sel_idx] = 1'b0;
    end
    // new arrivals are ORed after the clear so a same-cycle event survives
    if (q_ready) begin
      pend_nxt[25:0] = pend_nxt[25:0] | ev_new;
    end else if (|ev_new) begin
      pend_nxt[`OVF_BIT] = 1'b1;
    end
    pre_nxt   = (pre_r >= 14'(CYC_PER_MS - 1)) ? 14'h0000 : pre_r + 14'h0001;
    stamp_nxt = (pre_r >= 14'(CYC_PER_MS - 1)) ? stamp_r + 16'h0001 : stamp_r;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pend_r     <= 28'h400_0000;
      mon_prev_r <= 13'h0000;
      pre_r      <= 14'h0000;
      stamp_r    <= 16'h0000;
    end else begin
      pend_r     <= pend_nxt;
      mon_prev_r <= mon;
      pre_r      <= pre_nxt;
      stamp_r    <= stamp_nxt;
    end
  end

  event_queue #(.WIDTH(RECW), .DEPTH(QDEPTH)) u_queue (
    .i_sys_clk    (i_sys_clk),
    .i_rstn       (i_rstn),
    .i_push_valid (q_push),
    .o_push_ready (q_ready),
    .i_push_data  ({stamp_r, text_r, push_code}),
    .o_pop_valid  (o_ev_valid),
    .i_pop_ready  (i_ev_ready),
    .o_pop_data   ({o_ev_stamp, o_ev_text, o_ev_code})
  );

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_low_set_block: assert property (hs_s |=> !o_ls_oc_operate)
    else $error("low-set operated while high-set started");
  a_hs_routing: assert property (o_hs_oc_trip |-> $past(route_r) && $past(hs_op_s))
    else $error("high-set trip without routing");
  a_angle_set: assert property (o_basic_angle == ang_nxt || $changed(angle_r))
    else $error("basic angle not following its setting");
  a_ef_trip_time: assert property ($rose(o_ef_hs_trip) |-> $past(op_r) >= $past(op_lim))
    else $error("high-set earth-fault tripped early");
  a_gap_bound: assert property ((st_r == prot_event_pkg::EF_GAP) |-> rc_r <= gap_lim)
    else $error("reset timer ran past its limit");
  a_ext_cap: assert property (gap_r <= EXT_CAP)
    else $error("operate extension above its cap");
  a_mask_gate: assert property ((q_ready && pend_r[25:0] == 26'h000_0000)
    |=> (pend_r[25:0] & ~$past(mask_all)) == 26'h000_0000)
    else $error("masked event became pending");
  a_mask_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0) !i_rstn
    |=> oc_mask_r == `OC_MASK_RST && out_mask_r == `OUT_MASK_RST)
    else $error("mask reset value wrong");
  a_sys_kept: assert property ((pend_r[`OVF_BIT] && !(q_push && sel_idx == 5'(`OVF_BIT)))
    |=> pend_r[`OVF_BIT])
    else $error("system event lost");
  a_restart_first: assert property ($rose(i_rstn) |-> q_push && push_code == `CODE_RESTART)
    else $error("no restart event after reset");
  a_reject_keep: assert property ((i_set_wr && i_set_data > set_max)
    |=> o_set_rej && $stable(oc_mask_r) && $stable(ef_mask_r) && $stable(out_mask_r)
    && $stable(angle_r))
    else $error("out-of-range setting accepted");
  a_overflow_flag: assert property ((!q_ready && |ev_new) |=> pend_r[`OVF_BIT])
    else $error("overflow not flagged");

  c_restart: cover property (q_push && push_code == `CODE_RESTART);
  c_overflow: cover property (q_push && push_code == `CODE_OVERFLOW);
  c_ef_trip: cover property ($rose(o_ef_hs_trip));
  c_reject: cover property (o_set_rej);
endmodule

// ===== verification/event_sink.sv
// partner model: the event communicator that takes records off the event port
// assumes the block's clock; i_stall withholds ready so that the queue fills
`timescale 1ns/1ns
module event_sink (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_stall,
  input  wire logic        i_ev_valid,
  input  wire logic [15:0] i_ev_stamp,
  input  wire logic [7:0]  i_ev_text,
  input  wire logic [5:0]  i_ev_code,
  output logic             o_ev_ready,
  output logic             o_got,
  output logic [15:0]      o_got_stamp,
  output logic [7:0]       o_got_text,
  output logic [5:0]       o_got_code
);
  // link codes fifty-two to fifty-four are made on this side, never taken in
  always_ff @(posedge i_sys_clk) begin
    o_got <= 1'b0;
    if (!i_rstn) begin
      o_ev_ready <= 1'b0;
    end else begin
      if (i_ev_valid && o_ev_ready) begin
        o_got       <= 1'b1;
        o_got_stamp <= i_ev_stamp;
        o_got_text  <= i_ev_text;
        o_got_code  <= i_ev_code;
      end
      // random gaps in ready make the take slow as well as prompt
      o_ev_ready <= !i_stall && ($urandom_range(0, 3) != 0);
    end
  end
endmodule

// ===== verification/tb_protection_event_reporting.sv
// testbench: settings, mask gating, stage gating, timing, queue overflow
// assumes shortened timer parameters; inputs change on the falling edge
`timescale 1ns/1ns
module tb_protection_event_reporting;
  logic        clk = 0, rstn = 0, wr = 0, stall = 0, rdy, got, text_ok = 0, seen;
  logic [10:0] stim = '0;
  logic [2:0]  sel = '0;
  logic [9:0]  dat = '0, out_m;
  logic [15:0] stamp, g_stamp, last_stamp = '0;
  logic [7:0]  text, g_text, text_r, angle, oc_m, ef_m;
  logic [5:0]  code, g_code;
  logic        ls_op, hs_trip, ef_start, ef_trip, ts1, ts2, ack, rej, ev_valid;
  int          n_errors = 0, total_checks = 0, cyc = 0, m_oc, m_ef, m_out, n;
  int          exp[$];
  int          opc[2] = '{10, 40};
  int          bits[8] = '{0, 2, 4, 5, 6, 8, 9, 10};
  int          ups[8] = '{1, 5, 9, 11, 13, 19, 21, 23};
  logic [7:0]  ang[4] = '{8'h00, 8'he2, 8'hc4, 8'ha6};

  // stamp prescaler, extended time and depth stay at their defaults; the run never reaches the first two, the overflow test fills the eight-deep queue
  protection_event_reporting #(.OP_SHORT_CYC(10), .OP_LONG_CYC(40),
    .RST_CYC(10), .INT_RST_CYC(30), .EXT_CAP_CYC(30))
  u_protection_event_reporting (.i_sys_clk(clk), .i_rstn(rstn),
    .i_ls_oc_start(stim[0]), .i_ls_oc_operate(stim[1]), .i_hs_oc_start(stim[2]),
    .i_hs_oc_operate(stim[3]), .i_ef_ls_start(stim[4]), .i_ef_ls_operate(stim[5]),
    .i_residual_voltage_start(stim[6]), .i_ef_hs_pickup(stim[7]),
    .i_signal_one(stim[8]), .i_signal_two(stim[9]), .i_signal_three(stim[10]),
    .i_set_wr(wr), .i_set_sel(sel), .i_set_data(dat), .i_ev_ready(rdy),
    .o_ls_oc_operate(ls_op), .o_hs_oc_trip(hs_trip), .o_ef_hs_start(ef_start),
    .o_ef_hs_trip(ef_trip), .o_trip_signal_one(ts1), .o_trip_signal_two(ts2),
    .o_basic_angle(angle), .o_overcurrent_event_mask(oc_m),
    .o_earth_fault_event_mask(ef_m), .o_output_signal_event_mask(out_m),
    .o_set_ack(ack), .o_set_rej(rej), .o_ev_valid(ev_valid), .o_ev_stamp(stamp),
    .o_ev_text(text), .o_ev_code(code));

  event_sink u_event_sink (.i_sys_clk(clk), .i_rstn(rstn), .i_stall(stall),
    .i_ev_valid(ev_valid), .i_ev_stamp(stamp), .i_ev_text(text), .i_ev_code(code),
    .o_ev_ready(rdy), .o_got(got), .o_got_stamp(g_stamp), .o_got_text(g_text),
    .o_got_code(g_code));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // every record the communicator takes is compared with the model queue
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
    if (got) begin
      if (exp.size() == 0) chk("ev_extra", 16'h0000, 16'(g_code));
      else chk("ev_code", 16'(exp.pop_front()), 16'(g_code));
      if (text_ok) chk("ev_text", 16'(text_r), 16'(g_text));
      chk("ev_stamp", 16'h0001, 16'(g_stamp >= last_stamp));
      chk("ev_link_code", 16'h0000, 16'(g_code >= 6'h34 && g_code <= 6'h36));
      last_stamp = g_stamp;
    end
  end

  function automatic int lim(input int s);
    case (s)
      2: return 1023;
      3: return 3;
      4: return 2;
      5, 6: return 1;
      default: return 255;
    endcase
  endfunction

  function automatic void ev(input int i);
    int m;
    m = i <= 8 ? m_oc[i-1] : (i <= 16 ? m_ef[i-9] : m_out[i-17]);
    if (m != 0) exp.push_back(i);
  endfunction

  task automatic wrs(input int s, input int d);
    bit ok;
    ok = d <= lim(s);
    @(negedge clk);
    wr = 1;
    sel = 3'(s);
    dat = 10'(d);
    @(negedge clk);
    wr = 0;
    chk("set_ack", 16'(ok), 16'(ack));
    chk("set_rej", 16'(!ok), 16'(rej));
    if (ok && s == 0) m_oc = d;
    if (ok && s == 1) m_ef = d;
    if (ok && s == 2) m_out = d;
    if (ok && s == 7) text_r = 8'(d);
    if (ok && s == 7) text_ok = 1;
    chk("oc_mask", 16'(m_oc), 16'(oc_m));
    chk("ef_mask", 16'(m_ef), 16'(ef_m));
    chk("out_mask", 16'(m_out), 16'(out_m));
  endtask

  task automatic drain(input string nm);
    n = 0;
    while (exp.size() != 0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk("left_in_model", 16'h0000, 16'(exp.size()));
    exp.delete();
    $display("test %s done", nm);
  endtask

  task automatic do_reset;
    rstn = 0;
    repeat (8) @(negedge clk);
    chk("oc_mask_rst", 16'h0055, 16'(oc_m));
    chk("ef_mask_rst", 16'h0055, 16'(ef_m));
    chk("out_mask_rst", 16'h0300, 16'(out_m));
    chk("angle_rst", 16'h0000, 16'(angle));
    m_oc = 85;
    m_ef = 85;
    m_out = 768;
    text_ok = 0;
    last_stamp = '0;
    rstn = 1;
    exp.push_back(50);
    drain("reset");
  endtask

  task automatic tog(input int b, input int up);
    @(negedge clk);
    stim[b] = 1;
    ev(up);
    repeat (8) @(negedge clk);
    stim[b] = 0;
    ev(up + 1);
    repeat (8) @(negedge clk);
  endtask

  task automatic wt(input logic v);
    n = 0;
    while (ef_trip !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    void'($urandom(11981));
    do_reset;
    for (int k = 0; k < 5; k++) wrs(3, k);
    for (int k = 0; k < 4; k++) begin
      wrs(3, k);
      // the angle output is registered one cycle behind the setting
      @(negedge clk);
      chk("angle", 16'(ang[k]), 16'(angle));
    end
    wrs(0, 256);
    wrs(2, 1023);
    wrs(4, 3);
    repeat (24) wrs($urandom_range(0, 7), $urandom_range(0, 1023));
    wrs(7, $urandom_range(0, 255));
    drain("settings");
    repeat (3) begin
      wrs(0, $urandom_range(0, 255));
      wrs(1, $urandom_range(0, 255));
      wrs(2, $urandom_range(0, 1023));
      for (int i = 0; i < 8; i++) tog(bits[i], ups[i]);
    end
    drain("masks");
    wrs(0, 0);
    wrs(2, 0);
    wrs(6, 0);
    stim[2] = 1;
    stim[1] = 1;
    repeat (8) @(negedge clk);
    chk("ls_blocked", 16'h0000, 16'(ls_op));
    stim[3] = 1;
    repeat (8) @(negedge clk);
    chk("hs_unrouted", 16'h0000, 16'(hs_trip));
    wrs(6, 1);
    repeat (8) @(negedge clk);
    chk("hs_routed", 16'h0001, 16'(hs_trip));
    chk("trip_one", 16'h0001, 16'(ts1));
    stim[2] = 0;
    stim[3] = 0;
    repeat (8) @(negedge clk);
    chk("ls_free", 16'h0001, 16'(ls_op));
    stim[1] = 0;
    drain("stage_gating");
    wrs(1, 85);
    wrs(2, 768);
    wrs(5, 0);
    for (int k = 0; k < 2; k++) begin
      wrs(4, k);
      stim[7] = 1;
      ev(15);
      ev(25);
      wt(1);
      chk("op_window", 16'h0001, 16'(n >= opc[k] && n <= opc[k] + 6));
      chk("ef_start", 16'h0001, 16'(ef_start));
      chk("trip_two", 16'h0001, 16'(ts2));
      stim[7] = 0;
      ev(26);
      wt(0);
      chk("rst_window", 16'h0001, 16'(n >= 10 && n <= 16));
    end
    drain("ef_timing");
    for (int k = 0; k < 2; k++) begin
      wrs(5, k);
      seen = 0;
      for (int p = 0; p < 14 && !seen; p++) begin
        stim[7] = 1;
        repeat (4) @(negedge clk);
        stim[7] = 0;
        for (int g = 0; g < 15; g++) begin
          @(negedge clk);
          // expect the trip records before they can reach the communicator
          if (ef_trip === 1'b1 && !seen) begin
            ev(15);
            ev(25);
            ev(26);
          end
          if (ef_trip === 1'b1) seen = 1;
        end
      end
      chk("gap_bridged", 16'(k), 16'(seen));
      repeat (20) @(negedge clk);
    end
    drain("intermittent");
    wrs(0, 255);
    stall = 1;
    repeat (5) tog(0, 1);
    exp = exp[0:7];
    exp.push_back(51);
    wrs(0, 0);
    chk("ev_held", 16'h0001, 16'(ev_valid));
    stall = 0;
    drain("overflow");
    do_reset;
    stop_test;
  end
endmodule
